// File: logic/cpc_config.sv
// What this block does
// RQ1 - Host keeps unused noise select bits at zero.
// RQ2 - Through mode halts canceler and passes input samples unchanged.
// RQ3 - Code 00 17 dB, 11 13.5 dB, 10 8 dB, 01 through.
// RQ4 - Attenuation latched at end of initial mode; reset applies new one.
// RQ5 - Normal and through may be swapped while running without reset.
// RQ6 - Each effective select bit is register bit ORed with its pin.
// RQ7 - Host keeps register field zero when its pin controls a function.
// RQ8 - Unused pins tied inactive: reset pins high, others low.
// RQ9 - Parameter memory writes only in initial mode, mode bits 00.
// RQ10 - Host loads address, then data, then sets the write command.
// RQ11 - Device clears write command when done; writes may repeat.
// RQ12 - Single mode acoustic delay at 009Bh, default 01D8h; line halted.
// RQ13 - Dual mode acoustic 0099h default 0160h, line 009Ah default 0078h.
// RQ14 - Host keeps dual delays summing at most 59 ms.
// RQ15 - Host encodes delay as seconds times 8000, 0.125 ms steps.
// RQ16 - Coefficients at 01C8h and 01C2h apply only with select code 00.
// RQ17 - Ready flag reads one only during initial mode.
// RQ18 - Host polls write command for zero before the next write.
`timescale 1ns/1ps
`default_nettype none
module cpc_config #(
  parameter int SW    = 16,
  parameter int DEPTH = 512
) (
  // Clock and reset.
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write address.
  input  wire logic [cpc_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  // AXI4-Lite write data.
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  // AXI4-Lite write response.
  output logic      [1:0]                bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // AXI4-Lite read address.
  input  wire logic [cpc_pkg::AXI_AW-1:0] araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  // AXI4-Lite read data.
  output logic      [31:0]               rdata,
  output logic      [1:0]                rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // Control pins.
  input  wire logic                      powerdown_reset_n,
  input  wire logic                      noise_sel_low,
  input  wire logic                      noise_sel_high,
  input  wire logic                      echo_dual_sel,
  // Noise canceler sample path.
  input  wire logic [SW-1:0]             nc_in_sample,
  input  wire logic [SW-1:0]             nc_proc_sample,
  output logic      [SW-1:0]             nc_out_sample,
  // Noise canceler control.
  output logic                           nc_run,
  output logic                           nc_through,
  output cpc_pkg::cpc_atten_t            nc_atten,
  output logic                           nc_use_mem_coef,
  output logic      [15:0]               nc_coef1,
  output logic      [15:0]               nc_coef2,
  // Echo canceler parameters.
  output logic      [15:0]               acoustic_delay,
  output logic      [15:0]               line_delay,
  output logic                           line_ec_enable,
  // Device phase.
  output logic                           write_ready
);
  import cpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [3:0]  sync_meta;
  logic [3:0]  sync_q;
  logic        pin_pdn_n;
  logic        pin_nsl;
  logic        pin_nsh;
  logic        pin_dual;
  logic        pd;
  logic        soft_rst_n;

  cpc_state_t  state;
  cpc_state_t  next_state;

  logic        main_pdn;
  logic [1:0]  main_mode;
  logic        func_wcmd;
  logic        func_dual;
  logic        func_nsl;
  logic [7:0]  addr_hi;
  logic [7:0]  addr_lo;
  logic [7:0]  data_hi;
  logic [7:0]  data_lo;
  logic        nsel_high;

  logic        aw_got;
  logic [3:0]  aw_idx;
  logic        w_got;
  logic [7:0]  w_byte;
  logic        w_lane0;
  logic        do_write;
  logic [7:0]  rd_byte;
  logic [3:0]  ar_idx;
  logic        mem_wr;
  logic [1:0]  nc_code;
  logic        dual;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // True for the register indices that answer on the bus.
  function automatic logic is_mapped(input logic [3:0] idx);
    case (idx)
      IDX_MAIN, IDX_FUNC, IDX_ADDR_HI, IDX_ADDR_LO,
      IDX_DATA_HI, IDX_DATA_LO, IDX_STATUS, IDX_NSEL: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // A write lands on one register when the low byte lane is enabled.
  function automatic logic reg_wr(input logic [3:0] idx);
    reg_wr = do_write && w_lane0 && (aw_idx == idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  // Two flops per pin, reset to inactive levels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_meta <= 4'h1;
      sync_q    <= 4'h1;
    end else begin
      sync_meta <= {echo_dual_sel, noise_sel_high, noise_sel_low, powerdown_reset_n};
      sync_q    <= sync_meta;
    end
  end

  assign pin_pdn_n = sync_q[0];
  assign pin_nsl   = sync_q[1];
  assign pin_nsh   = sync_q[2];
  assign pin_dual  = sync_q[3];

  // Pin or control bit power-down clears the block.
  assign pd         = !pin_pdn_n || main_pdn; // [RQ4]
  assign soft_rst_n = aresetn && !pd;

  ////////////////////////////////////////////////////////////////////////////
  // Device phase.

  // Power-down, initial, then running once mode leaves 00.
  always_comb begin
    next_state = state;
    case (state)
      ST_PDOWN: begin
        next_state = ST_INITIAL;
      end
      ST_INITIAL: begin
        if (main_mode != MODE_INITIAL) begin
          next_state = ST_RUNNING; // [RQ9]
        end
      end
      ST_RUNNING: begin
        next_state = ST_RUNNING;
      end
      default: begin
        next_state = ST_PDOWN;
      end
    endcase
  end

  // Phase register, cleared by either reset.
  always_ff @(posedge aclk) begin
    if (!soft_rst_n) begin
      state <= ST_PDOWN;
    end else begin
      state <= next_state;
    end
  end

  // Ready marks the only phase that takes memory writes.
  assign write_ready = (state == ST_INITIAL); // [RQ17]

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel.

  // Each half is taken once; both stall while a response waits.
  assign awready  = !aw_got && !bvalid;
  assign wready   = !w_got && !bvalid;
  assign do_write = aw_got && w_got && !bvalid;

  // Address capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      aw_idx <= 4'h0;
    end else if (awvalid && awready) begin
      aw_got <= 1'b1;
      aw_idx <= awaddr[5:2];
    end else if (do_write) begin
      aw_got <= 1'b0;
    end
  end

  // Data capture; only the low byte carries register bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got   <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (wvalid && wready) begin
      w_got   <= 1'b1;
      w_byte  <= wdata[7:0];
      w_lane0 <= wstrb[0];
    end else if (do_write) begin
      w_got <= 1'b0;
    end
  end

  // Response after both halves are held; unmapped gives SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= is_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  // The power-down bit survives its own reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_pdn <= REG_RESET[MAIN_PDN_BIT];
    end else if (reg_wr(IDX_MAIN)) begin
      main_pdn <= w_byte[MAIN_PDN_BIT]; // [RQ4]
    end
  end

  // Mode bits; a return to 00 while running is ignored.
  always_ff @(posedge aclk) begin
    if (!soft_rst_n) begin
      main_mode <= REG_RESET[1:0];
    end else if (reg_wr(IDX_MAIN) && !w_byte[MAIN_PDN_BIT]) begin
      if (state != ST_RUNNING || w_byte[1:0] != MODE_INITIAL) begin
        main_mode <= w_byte[1:0]; // [RQ9]
      end
    end
  end

  // A host write of the command wins over the clear.
  always_ff @(posedge aclk) begin
    if (!soft_rst_n) begin
      func_wcmd <= REG_RESET[FUNC_WCMD_BIT];
      func_dual <= REG_RESET[FUNC_DUAL_BIT];
      func_nsl  <= REG_RESET[FUNC_NSL_BIT];
    end else begin
      if (func_wcmd) begin
        func_wcmd <= 1'b0; // [RQ11]
      end
      if (reg_wr(IDX_FUNC)) begin
        func_wcmd <= w_byte[FUNC_WCMD_BIT];
        func_dual <= w_byte[FUNC_DUAL_BIT];
        func_nsl  <= w_byte[FUNC_NSL_BIT];
      end
    end
  end

  // Memory address and data pairs.
  always_ff @(posedge aclk) begin
    if (!soft_rst_n) begin
      addr_hi <= REG_RESET;
      addr_lo <= REG_RESET;
      data_hi <= REG_RESET;
      data_lo <= REG_RESET;
    end else begin
      if (reg_wr(IDX_ADDR_HI)) begin
        addr_hi <= w_byte;
      end
      if (reg_wr(IDX_ADDR_LO)) begin
        addr_lo <= w_byte;
      end
      if (reg_wr(IDX_DATA_HI)) begin
        data_hi <= w_byte;
      end
      if (reg_wr(IDX_DATA_LO)) begin
        data_lo <= w_byte;
      end
    end
  end

  // Only the high select bit is stored; others read zero.
  always_ff @(posedge aclk) begin
    if (!soft_rst_n) begin
      nsel_high <= REG_RESET[NSEL_HIGH_BIT];
    end else if (reg_wr(IDX_NSEL)) begin
      nsel_high <= w_byte[NSEL_HIGH_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.

  assign arready = !rvalid;
  assign ar_idx  = araddr[5:2];

  // Read multiplexer; status shows the device phase.
  always_comb begin
    rd_byte = 8'h00;
    case (ar_idx)
      IDX_MAIN:    rd_byte = {main_pdn, 5'h00, main_mode};
      IDX_FUNC:    rd_byte = {func_wcmd, 5'h00, func_dual, func_nsl};
      IDX_ADDR_HI: rd_byte = addr_hi;
      IDX_ADDR_LO: rd_byte = addr_lo;
      IDX_DATA_HI: rd_byte = data_hi;
      IDX_DATA_LO: rd_byte = data_lo;
      IDX_STATUS:  rd_byte = {write_ready, 7'h00}; // [RQ17]
      IDX_NSEL:    rd_byte = {5'h00, nsel_high, 2'h0};
      default:     rd_byte = 8'h00;
    endcase
  end

  // Read data registered when the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rd_byte};
      rresp  <= is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter memory.

  // A command writes only in initial mode; otherwise it just clears.
  assign mem_wr = func_wcmd && (state == ST_INITIAL); // [RQ9] [RQ11]
  assign dual   = func_dual || pin_dual;
  assign line_ec_enable = dual && (state == ST_RUNNING); // [RQ12]

  cpc_param_mem #(
    .DEPTH(DEPTH)
  ) u_mem (
    .clk            (aclk),
    .rst_n          (soft_rst_n),
    .wr_en          (mem_wr),
    .wr_addr        ({addr_hi, addr_lo}),
    .wr_data        ({data_hi, data_lo}),
    .dual           (dual),
    .acoustic_delay (acoustic_delay),
    .line_delay     (line_delay),
    .coef1          (nc_coef1),
    .coef2          (nc_coef2)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Noise canceler selection.

  // Each select bit is register bit ORed with pin.
  assign nc_code = {nsel_high || pin_nsh, func_nsl || pin_nsl}; // [RQ6]

  cpc_nc_select #(
    .SW(SW)
  ) u_nc (
    .clk          (aclk),
    .rst_n        (soft_rst_n),
    .code         (nc_code),
    .initial_mode (write_ready),
    .running      (state == ST_RUNNING),
    .in_sample    (nc_in_sample),
    .proc_sample  (nc_proc_sample),
    .out_sample   (nc_out_sample),
    .run          (nc_run),
    .through      (nc_through),
    .atten        (nc_atten),
    .use_mem_coef (nc_use_mem_coef)
  );
endmodule
`default_nettype wire

// File: logic/cpc_pkg.sv
`default_nettype none
package cpc_pkg;
  // Register bus geometry: one aligned word per register, index times four.
  localparam int AXI_AW = 6;
  localparam int REG_W  = 8;
  localparam logic [3:0] IDX_MAIN    = 4'h0;
  localparam logic [3:0] IDX_FUNC    = 4'h1;
  localparam logic [3:0] IDX_ADDR_HI = 4'h6;
  localparam logic [3:0] IDX_ADDR_LO = 4'h7;
  localparam logic [3:0] IDX_DATA_HI = 4'h8;
  localparam logic [3:0] IDX_DATA_LO = 4'h9;
  localparam logic [3:0] IDX_STATUS  = 4'hB;
  localparam logic [3:0] IDX_NSEL    = 4'hC;
  localparam logic [7:0] REG_RESET   = 8'h00;
  // Field positions.
  localparam int MAIN_PDN_BIT   = 7;
  localparam int FUNC_WCMD_BIT  = 7;
  localparam int FUNC_DUAL_BIT  = 1;
  localparam int FUNC_NSL_BIT   = 0;
  localparam int STAT_READY_BIT = 7;
  localparam int NSEL_HIGH_BIT  = 2;
  localparam logic [1:0] MODE_INITIAL = 2'h0;
  localparam logic [1:0] NC_CODE_THRU = 2'h1;
  localparam logic [1:0] NC_CODE_MEM  = 2'h0;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Parameter memory map and default words.
  localparam int MEM_AW = 9;
  localparam logic [8:0]  MA_AC_SINGLE = 9'h09B;
  localparam logic [8:0]  MA_AC_DUAL   = 9'h099;
  localparam logic [8:0]  MA_LINE      = 9'h09A;
  localparam logic [8:0]  MA_COEF1     = 9'h1C8;
  localparam logic [8:0]  MA_COEF2     = 9'h1C2;
  localparam logic [15:0] DEF_AC_SINGLE = 16'h01D8;
  localparam logic [15:0] DEF_AC_DUAL   = 16'h0160;
  localparam logic [15:0] DEF_LINE      = 16'h0078;
  localparam logic [15:0] DEF_COEF1     = 16'h2000;
  localparam logic [15:0] DEF_COEF2     = 16'h0005;

  typedef enum logic [1:0] {ST_PDOWN, ST_INITIAL, ST_RUNNING} cpc_state_t;
  typedef enum logic [1:0] {ATT_17DB, ATT_13P5DB, ATT_8DB} cpc_atten_t;

  // Default content of a parameter memory word.
  function automatic logic [15:0] cpc_mem_default(input logic [8:0] a);
    case (a)
      MA_AC_SINGLE: cpc_mem_default = DEF_AC_SINGLE;
      MA_AC_DUAL:   cpc_mem_default = DEF_AC_DUAL;
      MA_LINE:      cpc_mem_default = DEF_LINE;
      MA_COEF1:     cpc_mem_default = DEF_COEF1;
      MA_COEF2:     cpc_mem_default = DEF_COEF2;
      default:      cpc_mem_default = 16'h0000;
    endcase
  endfunction

  // Attenuation of a select code, high bit first; through falls back to 17 dB.
  function automatic cpc_atten_t cpc_atten(input logic [1:0] code);
    case (code)
      2'h3:    cpc_atten = ATT_13P5DB;
      2'h2:    cpc_atten = ATT_8DB;
      default: cpc_atten = ATT_17DB;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: logic/cpc_param_mem.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_param_mem #(
  parameter int DEPTH = 512
) (
  // Clock and soft reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write port.
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_addr,
  input  wire logic [15:0] wr_data,
  // Echo mode and parameter words.
  input  wire logic        dual,
  output logic      [15:0] acoustic_delay,
  output logic      [15:0] line_delay,
  output logic      [15:0] coef1,
  output logic      [15:0] coef2
);
  import cpc_pkg::*;
  logic [15:0] mem [DEPTH];
  integer i;

  ////////////////////////////////////////////////////////////////////////////
  // Defaults reload on every reset; out-of-range writes drop.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= cpc_mem_default(i[8:0]);
      end
    end else if (wr_en && (wr_addr < 16'(DEPTH))) begin
      mem[wr_addr[8:0]] <= wr_data; // [RQ11]
    end
  end

  // Fixed parameter words, the acoustic one chosen by echo mode.
  always_ff @(posedge clk) begin
    acoustic_delay <= dual ? mem[MA_AC_DUAL] : mem[MA_AC_SINGLE]; // [RQ12] [RQ13]
    line_delay     <= mem[MA_LINE]; // [RQ13]
    coef1          <= mem[MA_COEF1]; // [RQ16]
    coef2          <= mem[MA_COEF2]; // [RQ16]
  end
endmodule
`default_nettype wire

// File: logic/cpc_nc_select.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_nc_select #(
  parameter int SW = 16
) (
  // Clock and soft reset.
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Effective select code and device phase.
  input  wire logic [1:0]          code,
  input  wire logic                initial_mode,
  input  wire logic                running,
  // Sample path.
  input  wire logic [SW-1:0]       in_sample,
  input  wire logic [SW-1:0]       proc_sample,
  output logic      [SW-1:0]       out_sample,
  // Canceler control.
  output logic                     run,
  output logic                     through,
  output cpc_pkg::cpc_atten_t      atten,
  output logic                     use_mem_coef
);
  import cpc_pkg::*;
  logic [1:0] lat_code;

  ////////////////////////////////////////////////////////////////////////////
  // Code follows the effective select code during initial mode and freezes when it ends.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lat_code <= 2'h0;
    end else if (initial_mode) begin
      lat_code <= code; // [RQ4]
    end
  end

  // Through follows the live code, so it may toggle while running.
  always_comb begin
    run          = running && (code != NC_CODE_THRU); // [RQ2] [RQ5]
    through      = !run;
    atten        = cpc_atten(lat_code); // [RQ3] [RQ4]
    use_mem_coef = (lat_code == NC_CODE_MEM); // [RQ16]
  end

  // Processed sample when running, input unchanged otherwise.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_sample <= '0;
    end else begin
      out_sample <= run ? proc_sample : in_sample; // [RQ2]
    end
  end
endmodule
`default_nettype wire

// File: tb/cpc_config_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_config_checker #(
  parameter int SW = 16
) (
  // Clock, reset and echo mode pin.
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                echo_dual_sel,
  // Sample path.
  input wire logic [SW-1:0]       nc_in_sample,
  input wire logic [SW-1:0]       nc_proc_sample,
  input wire logic [SW-1:0]       nc_out_sample,
  // Canceler control, parameters and phase.
  input wire logic                nc_run,
  input wire logic                nc_through,
  input wire cpc_pkg::cpc_atten_t nc_atten,
  input wire logic                nc_use_mem_coef,
  input wire logic [15:0]         nc_coef1,
  input wire logic [15:0]         nc_coef2,
  input wire logic [15:0]         acoustic_delay,
  input wire logic [15:0]         line_delay,
  input wire logic                line_ec_enable,
  input wire logic                write_ready
);
  import cpc_pkg::*;
  // All checks share the bus clock and reset.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  a_pass_initial: assert property (
    write_ready ##1 write_ready |-> nc_out_sample == $past(nc_in_sample))
    else $error("Input not passed.");
  a_run_processed: assert property (
    nc_run ##1 nc_run |-> nc_out_sample == $past(nc_proc_sample))
    else $error("Processed not passed.");
  a_ready_idle: assert property (
    write_ready |-> !nc_run)
    else $error("Runs in initial mode.");
  a_atten_frozen: assert property (
    nc_run && $past(nc_run) |-> $stable(nc_atten))
    else $error("Attenuation changed.");
  a_mem_coef_17db: assert property (
    nc_use_mem_coef |-> nc_atten == ATT_17DB)
    else $error("Bad coefficient use.");
  a_reset_defaults: assert property (
    $rose(aresetn) && !echo_dual_sel |-> acoustic_delay == DEF_AC_SINGLE
      && line_delay == DEF_LINE && nc_coef1 == DEF_COEF1 && nc_coef2 == DEF_COEF2)
    else $error("Defaults not restored.");
  a_ready_after_reset: assert property (
    $rose(aresetn) |-> ##[1:4] write_ready)
    else $error("No initial mode.");
  a_line_running: assert property (
    line_ec_enable |-> !write_ready)
    else $error("Line on in initial mode.");
  a_coef_locked: assert property (
    nc_run && $past(nc_run) |-> $stable(nc_coef1) && $stable(nc_coef2))
    else $error("Coefficients changed.");
  // Main scenarios reached.
  c_through_run: cover property (nc_through && !write_ready);
  c_line_on: cover property (line_ec_enable);
  c_att_8db: cover property (nc_run && nc_atten == ATT_8DB);
endmodule
bind cpc_config cpc_config_checker #(.SW(SW)) u_cpc_config_checker (.*);
`default_nettype wire

// File: tb/cpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_host_model (
  // Clock.
  input  wire logic        aclk,
  // Write channels.
  output var  logic [5:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  // Read channels.
  output var  logic [5:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  import cpc_pkg::*;
  // Idle bus; responses taken at once.
  initial begin
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    bready = 1'b1;
    rready = 1'b1;
  end
  ////////////////////////////////////////
  // One register write; released payload is inverted.
  task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~{24'h0, d};
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
  endtask
  // One register read.
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge aclk); while (!rvalid);
    d = rdata[7:0];
    r = rresp;
  endtask
  // Parameter write, then poll the command bit.
  task automatic mem_wr(input logic [15:0] a, input logic [15:0] d);
    logic [1:0] r;
    logic [7:0] v;
    wr(6'h18, a[15:8], r);
    wr(6'h1C, a[7:0], r);
    wr(6'h20, d[15:8], r);
    wr(6'h24, d[7:0], r);
    wr(6'h04, 8'h80, r);
    do rd(6'h04, v, r); while (v[7]);
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cpc_pkg::*;
  // Clock, reset and pins.
  logic              aclk, aresetn, powerdown_reset_n;
  logic              noise_sel_low, noise_sel_high, echo_dual_sel;
  // Register bus.
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  // Canceler side.
  logic [15:0]       nc_in_sample, nc_proc_sample, nc_out_sample;
  logic [15:0]       nc_coef1, nc_coef2, acoustic_delay, line_delay;
  logic              nc_run, nc_through, nc_use_mem_coef, line_ec_enable, write_ready;
  cpc_atten_t        nc_atten;
  int                err_count;
  int                total_checks;
  logic [1:0]        r;
  logic [7:0]        v;
  cpc_config u_cpc_config (.*);
  cpc_host_model u_host (.*);
  ////////////////////////////////////////
  // Compares and counts; reports a mismatch at once.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  // Reset values, the select bit and an unmapped place.
  task automatic t_regs;
    u_host.rd(6'h30, v, r);
    chk(16'(v), 16'(REG_RESET));
    u_host.rd(6'h2C, v, r);
    chk(16'(v), 16'h0080);
    u_host.wr(6'h30, 8'h04, r); // Unused bits stay zero.
    u_host.rd(6'h30, v, r);
    chk(16'(v), 16'h0004);
    u_host.rd(6'h3C, v, r);
    chk(16'(r), 16'(RESP_SLVERR));
  endtask
  // Each normal code by register and pin, frozen while running.
  task automatic t_atten;
    logic [1:0] codes [3] = '{2'h0, 2'h3, 2'h2};
    cpc_atten_t att [3] = '{ATT_17DB, ATT_13P5DB, ATT_8DB};
    for (int i = 0; i < 3; i++) begin
      do_reset;
      u_host.wr(6'h30, {5'h0, codes[i][1] & i[0], 2'h0}, r);
      noise_sel_high <= codes[i][1] & ~i[0]; // Register field left zero.
      noise_sel_low <= codes[i][0];
      repeat (4) @(posedge aclk);
      u_host.wr(6'h00, 8'h01, r);
      repeat (2) @(posedge aclk);
      chk(16'(nc_atten), 16'(att[i]));
      chk(16'(nc_use_mem_coef), 16'(i == 0));
      chk(16'(nc_run), 16'h0001);
      noise_sel_high <= 1'b1;
      noise_sel_low <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(16'(nc_atten), 16'(att[i]));
      noise_sel_high <= 1'b0;
    end
  endtask
  // Back-to-back parameter writes in initial mode.
  task automatic t_mem;
    do_reset;
    u_host.mem_wr(16'h009B, 16'h00F0); // 30 ms times 8000 is 240.
    chk(acoustic_delay, 16'h00F0);
    u_host.mem_wr(16'h01C8, 16'h3333);
    u_host.mem_wr(16'h01C2, 16'h0004);
    chk(nc_coef1, 16'h3333);
    chk(nc_coef2, 16'h0004);
  endtask
  // Through and back while running; memory writes refused.
  task automatic t_run;
    nc_in_sample <= 16'h1234;
    nc_proc_sample <= 16'hABCD;
    u_host.wr(6'h00, 8'h01, r);
    repeat (2) @(posedge aclk);
    chk(nc_out_sample, 16'hABCD);
    noise_sel_low <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(nc_out_sample, 16'h1234);
    chk(16'(nc_through), 16'h0001);
    noise_sel_low <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(nc_out_sample, 16'hABCD);
    u_host.mem_wr(16'h009B, 16'h0010);
    chk(acoustic_delay, 16'h00F0);
    u_host.rd(6'h2C, v, r);
    chk(16'(v), 16'h0000);
  endtask
  // Pin reset with dual echo mode defaults, then bit reset and line canceler on.
  task automatic t_pdn;
    powerdown_reset_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(16'(write_ready), 16'h0000);
    powerdown_reset_n <= 1'b1;
    echo_dual_sel <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(16'(write_ready), 16'h0001);
    chk(acoustic_delay, DEF_AC_DUAL);
    chk(line_delay, DEF_LINE);
    chk(acoustic_delay + line_delay, DEF_AC_SINGLE);
    u_host.wr(6'h00, 8'h80, r);
    repeat (2) @(posedge aclk);
    chk(16'(write_ready), 16'h0000);
    u_host.wr(6'h00, 8'h00, r);
    repeat (3) @(posedge aclk);
    chk(16'(write_ready), 16'h0001);
    u_host.wr(6'h00, 8'h01, r);
    repeat (2) @(posedge aclk);
    chk(16'(line_ec_enable), 16'h0001);
  endtask
  ////////////////////////////////////////
  // Clock generator.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    complete_run;
  end
  // Unused pins idle inactive, reset pin high.
  initial begin
    err_count = 0;
    total_checks = 0;
    aresetn = 1'b0;
    powerdown_reset_n = 1'b1;
    noise_sel_low = 1'b0;
    noise_sel_high = 1'b0;
    echo_dual_sel = 1'b0;
    nc_in_sample = 16'h0000;
    nc_proc_sample = 16'h0000;
    do_reset;
    t_regs;
    t_atten;
    t_mem;
    t_run;
    t_pdn;
    complete_run;
  end
endmodule
`default_nettype wire
